// >>> src/cow_defines.vh
// constants for the charger control options block
`ifndef COW_DEFINES_VH
`define COW_DEFINES_VH

`define COW_ADDR_OPTIONS 8'h12
`define COW_ADDR_CHG_CURRENT 8'h14
`define COW_ADDR_CHG_VOLTAGE 8'h15
`define COW_OPTIONS_RESET 16'hE20E
// writable bits: all but reserved 8..6
`define COW_OPTIONS_WMASK 16'hFE3F

`define COW_BIT_LOW_POWER 15
`define COW_BIT_WD_HI 14
`define COW_BIT_WD_LO 13
`define COW_BIT_LIMIT_AUTO_OFF 12
`define COW_BIT_SRC_ON_GOOD 11
`define COW_BIT_OUT_OF_AUDIO 10
`define COW_BIT_SW_FREQ 9
`define COW_BIT_LEARN 5
`define COW_BIT_INPUT_REG 1

`define COW_WD_OFF 2'h0
`define COW_WD_SEL_5S 2'h1
`define COW_WD_SEL_88S 2'h2
`define COW_WD_SEL_175S 2'h3
`define COW_WD_SEC_5 8'h05
`define COW_WD_SEC_88 8'h58
`define COW_WD_SEC_175 8'hAF

`define COW_CLOCK_HZ 25000000
`define COW_TICKS_PER_SEC (`COW_CLOCK_HZ)

`endif

// >>> src/cow_charger_options.v
// charger control options register with charge-command watchdog
// Overview of operation
// - 16-bit options register at 12h, resets E20Eh
// - low power on battery disables monitors, ADC
// - performance mode: monitors follow own settings
// - comparator still enabled by option1 bit 14/13
// - watchdog period select: off, 5, 88, 175 s
// - watchdog expiry suspends charging at zero current
// - restart by writing 14h, 15h or 12h; charging resumes only if charge values are valid
// - presence pin low clears input regulation enable when bit 12 is set
// - host may re-enable input regulation later
// - source mode drives adapter good high
// - out-of-audio keeps burst frequency above 25 kHz
// - bit 9 selects 1200 or 800 kHz
// - presence pin low clears learn discharge enable
`timescale 1ns/1ns
`include "cow_defines.vh"

module cow_charger_options #(
  parameter [24:0] TICKS_PER_SEC = `COW_TICKS_PER_SEC
) (
  // clock and reset
  input wire CLOCK,
  input wire RESET,
  // decoded host command port
  input wire CMD_WRITE,
  input wire CMD_READ,
  input wire [7:0] CMD_ADDR,
  input wire [15:0] CMD_WDATA,
  output reg [15:0] CMD_RDATA,
  output reg CMD_RVALID,
  // pins and analog status, asynchronous
  input wire BATTERY_PRESENCE_PIN,
  input wire BATTERY_ONLY,
  input wire OTG_MODE,
  input wire ADAPTER_PRESENT,
  // settings from neighbouring registers, same clock
  input wire PROCHOT_CFG,
  input wire DISCHG_MON_CFG,
  input wire POWER_MON_CFG,
  input wire COMPARATOR_CFG,
  input wire OPT1_CMP_BIT14,
  input wire OPT1_CMP_BIT13,
  input wire CHARGE_VALUES_VALID,
  // controls to the analog side
  output reg PROCHOT_ENABLE,
  output reg DISCHG_MON_ENABLE,
  output reg POWER_MON_ENABLE,
  output reg COMPARATOR_ENABLE,
  output reg ADC_AVAILABLE,
  output reg CHARGE_SUSPEND,
  output reg ADAPTER_GOOD_OUTPUT,
  output reg INPUT_REG_ENABLE,
  output reg BURST_LIMIT_ENABLE,
  output reg SW_FREQ_800K,
  output reg LEARN_ENABLE
);

  reg [15:0] options_q;
  reg [15:0] options_d;
  reg [2:0] pres_sync_q;
  reg [2:0] batt_sync_q;
  reg [1:0] otg_sync_q;
  reg [1:0] adpt_sync_q;
  reg [24:0] tick_q;
  reg [7:0] sec_q;
  reg suspend_q;
  wire pres_fell;
  wire batt_only;
  wire low_power;
  wire wr_opt;
  wire wd_restart;
  wire [1:0] wd_sel;
  wire wd_run;
  wire wd_expire;
  wire sec_tick;

  function [7:0] wd_limit;
    input [1:0] sel;
    begin
      case (sel)
        `COW_WD_SEL_5S: wd_limit = `COW_WD_SEC_5;
        `COW_WD_SEL_88S: wd_limit = `COW_WD_SEC_88;
        `COW_WD_SEL_175S: wd_limit = `COW_WD_SEC_175;
        default: wd_limit = 8'h00;
      endcase
    end
  endfunction

  // second stage is the first one logic may look at; third is only for the edge
  assign pres_fell = pres_sync_q[2] & ~pres_sync_q[1];
  assign batt_only = batt_sync_q[1];
  assign low_power = options_q[`COW_BIT_LOW_POWER] & batt_only;
  assign wr_opt = CMD_WRITE & (CMD_ADDR == `COW_ADDR_OPTIONS);
  assign wd_restart = CMD_WRITE & ((CMD_ADDR == `COW_ADDR_CHG_CURRENT) |
                                   (CMD_ADDR == `COW_ADDR_CHG_VOLTAGE) | wr_opt);
  assign wd_sel = options_q[`COW_BIT_WD_HI:`COW_BIT_WD_LO];
  assign wd_run = (wd_sel != `COW_WD_OFF) & ~suspend_q;
  assign sec_tick = (tick_q == TICKS_PER_SEC - 25'h0000001);
  assign wd_expire = wd_run & sec_tick & (sec_q + 8'h01 >= wd_limit(wd_sel));

  // presence resets high, its idle level, so no false falling edge follows reset
  always @(posedge CLOCK) begin
    if (RESET) begin
      pres_sync_q <= 3'h7;
    end else begin
      pres_sync_q <= {pres_sync_q[1:0], BATTERY_PRESENCE_PIN};
    end
  end

  always @(posedge CLOCK) begin
    if (RESET) begin
      batt_sync_q <= 3'h0;
    end else begin
      batt_sync_q <= {batt_sync_q[1:0], BATTERY_ONLY};
    end
  end

  always @(posedge CLOCK) begin
    if (RESET) begin
      otg_sync_q <= 2'h0;
    end else begin
      otg_sync_q <= {otg_sync_q[0], OTG_MODE};
    end
  end

  always @(posedge CLOCK) begin
    if (RESET) begin
      adpt_sync_q <= 2'h0;
    end else begin
      adpt_sync_q <= {adpt_sync_q[0], ADAPTER_PRESENT};
    end
  end

  // hardware clears first, a host write in the same cycle then wins
  always @* begin
    options_d = options_q;
    if (pres_fell) begin
      options_d[`COW_BIT_LEARN] = 1'b0;
      if (options_q[`COW_BIT_LIMIT_AUTO_OFF]) begin
        options_d[`COW_BIT_INPUT_REG] = 1'b0;
      end
    end
    if (wr_opt) begin
      options_d = CMD_WDATA & `COW_OPTIONS_WMASK;
    end
  end

  always @(posedge CLOCK) begin
    if (RESET) begin
      options_q <= `COW_OPTIONS_RESET;
    end else begin
      options_q <= options_d;
    end
  end

  // watchdog: prescaler to seconds, then compare against the selected period
  always @(posedge CLOCK) begin
    if (RESET) begin
      tick_q <= 25'h0000000;
      sec_q <= 8'h00;
      suspend_q <= 1'b0;
    end else if (wd_restart) begin
      tick_q <= 25'h0000000;
      sec_q <= 8'h00;
      if (suspend_q & CHARGE_VALUES_VALID) begin
        suspend_q <= 1'b0;
      end
    end else if (wd_expire) begin
      tick_q <= 25'h0000000;
      sec_q <= 8'h00;
      suspend_q <= 1'b1;
    end else if (wd_run) begin
      if (sec_tick) begin
        tick_q <= 25'h0000000;
        sec_q <= sec_q + 8'h01;
      end else begin
        tick_q <= tick_q + 25'h0000001;
      end
    end else begin
      tick_q <= 25'h0000000;
      sec_q <= 8'h00;
    end
  end

  // host read port answers one cycle after the request
  always @(posedge CLOCK) begin
    if (RESET) begin
      CMD_RDATA <= 16'h0000;
      CMD_RVALID <= 1'b0;
    end else begin
      CMD_RVALID <= CMD_READ;
      if (CMD_READ & (CMD_ADDR == `COW_ADDR_OPTIONS)) begin
        CMD_RDATA <= options_q;
      end else begin
        CMD_RDATA <= 16'h0000;
      end
    end
  end

  // registered controls toward the converter and monitors, one flop each
  always @(posedge CLOCK) begin
    if (RESET) begin
      PROCHOT_ENABLE <= 1'b0;
    end else begin
      PROCHOT_ENABLE <= PROCHOT_CFG & ~low_power;
    end
  end

  always @(posedge CLOCK) begin
    if (RESET) begin
      DISCHG_MON_ENABLE <= 1'b0;
    end else begin
      DISCHG_MON_ENABLE <= DISCHG_MON_CFG & ~low_power;
    end
  end

  always @(posedge CLOCK) begin
    if (RESET) begin
      POWER_MON_ENABLE <= 1'b0;
    end else begin
      POWER_MON_ENABLE <= POWER_MON_CFG & ~low_power;
    end
  end

  // the comparator survives low power when option 1 asks for it
  always @(posedge CLOCK) begin
    if (RESET) begin
      COMPARATOR_ENABLE <= 1'b0;
    end else begin
      COMPARATOR_ENABLE <= low_power ? (OPT1_CMP_BIT14 | OPT1_CMP_BIT13) :
                           COMPARATOR_CFG;
    end
  end

  always @(posedge CLOCK) begin
    if (RESET) begin
      ADC_AVAILABLE <= 1'b0;
    end else begin
      ADC_AVAILABLE <= ~low_power;
    end
  end

  always @(posedge CLOCK) begin
    if (RESET) begin
      CHARGE_SUSPEND <= 1'b0;
    end else begin
      CHARGE_SUSPEND <= suspend_q;
    end
  end

  always @(posedge CLOCK) begin
    if (RESET) begin
      ADAPTER_GOOD_OUTPUT <= 1'b0;
    end else begin
      ADAPTER_GOOD_OUTPUT <= adpt_sync_q[1] |
                             (options_q[`COW_BIT_SRC_ON_GOOD] & otg_sync_q[1]);
    end
  end

  always @(posedge CLOCK) begin
    if (RESET) begin
      INPUT_REG_ENABLE <= 1'b1;
    end else begin
      INPUT_REG_ENABLE <= options_q[`COW_BIT_INPUT_REG];
    end
  end

  always @(posedge CLOCK) begin
    if (RESET) begin
      BURST_LIMIT_ENABLE <= 1'b0;
    end else begin
      BURST_LIMIT_ENABLE <= options_q[`COW_BIT_OUT_OF_AUDIO];
    end
  end

  always @(posedge CLOCK) begin
    if (RESET) begin
      SW_FREQ_800K <= 1'b1;
    end else begin
      SW_FREQ_800K <= options_q[`COW_BIT_SW_FREQ];
    end
  end

  always @(posedge CLOCK) begin
    if (RESET) begin
      LEARN_ENABLE <= 1'b0;
    end else begin
      LEARN_ENABLE <= options_q[`COW_BIT_LEARN];
    end
  end

endmodule

// >>> tb/cow_properties.sv
// port assertions for the charger options block
`timescale 1ns/1ns
module cow_properties (
  input wire CLOCK,
  input wire RESET,
  input wire CMD_WRITE,
  input wire CMD_READ,
  input wire [7:0] CMD_ADDR,
  input wire [15:0] CMD_WDATA,
  input wire [15:0] CMD_RDATA,
  input wire CMD_RVALID,
  input wire PROCHOT_CFG,
  input wire OPT1_CMP_BIT14,
  input wire OPT1_CMP_BIT13,
  input wire CHARGE_VALUES_VALID,
  input wire PROCHOT_ENABLE,
  input wire COMPARATOR_ENABLE,
  input wire ADC_AVAILABLE,
  input wire CHARGE_SUSPEND,
  input wire BURST_LIMIT_ENABLE,
  input wire SW_FREQ_800K
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  chk_read_answer: assert property (CMD_READ |=> CMD_RVALID)
    else $error("read not answered");
  chk_reserved_zero: assert property (CMD_RVALID |-> CMD_RDATA[8:6] == 3'h0)
    else $error("reserved bits set");
  chk_low_power_gate: assert property (!ADC_AVAILABLE |-> !PROCHOT_ENABLE)
    else $error("monitor on in low power");
  chk_low_power_comp: assert property (!ADC_AVAILABLE |->
    COMPARATOR_ENABLE == ($past(OPT1_CMP_BIT14) | $past(OPT1_CMP_BIT13)))
    else $error("comparator gate wrong");
  chk_perf_follow: assert property (ADC_AVAILABLE |-> PROCHOT_ENABLE == $past(PROCHOT_CFG))
    else $error("monitor ignores setting");
  chk_burst_follow: assert property (CMD_WRITE && CMD_ADDR == 8'h12 |=>
    ##1 BURST_LIMIT_ENABLE == $past(CMD_WDATA[10], 2)) else $error("burst limit wrong");
  chk_freq_follow: assert property (CMD_WRITE && CMD_ADDR == 8'h12 |=>
    ##1 SW_FREQ_800K == $past(CMD_WDATA[9], 2)) else $error("frequency select wrong");
  chk_resume_cause: assert property ($fell(CHARGE_SUSPEND) |->
    $past(CMD_WRITE && CHARGE_VALUES_VALID, 2)) else $error("resume without write");
endmodule

// >>> tb/cow_host.sv
// host controller model issuing decoded command words
`timescale 1ns/1ns
module cow_host (
  // clock
  input wire clk,
  // command port
  output reg wr,
  output reg rd,
  output reg [7:0] addr,
  output reg [15:0] wdata
);
  initial {wr, rd, addr, wdata} = 26'h0;
  // one word per call; data is inverted after the request so it is never trusted
  task xfer(input w, input [7:0] a, input [15:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    wdata <= ~d;
  endtask
endmodule

// >>> tb/testbench.sv
// self-checking bench for the charger options block
`timescale 1ns/1ns
module testbench;
  reg clk = 0, rst = 1, bp = 1, bo = 0, otg = 0, ap = 0, vv = 1;
  reg [5:0] cf = 6'h0;
  reg [31:0] sd = 32'h3BA6;
  reg [15:0] eq[$];
  wire wr, rd, rv;
  wire [7:0] a;
  wire [15:0] wd, rq, o;
  integer err_total = 0, comparisons = 0, n;
  always #20 clk = ~clk;
  assign o[15:11] = 5'h0;
  cow_host u_host(.clk(clk), .wr(wr), .rd(rd), .addr(a), .wdata(wd));
  cow_charger_options #(.TICKS_PER_SEC(25'h2)) i_cow_charger_options(.CLOCK(clk),
    .RESET(rst), .CMD_WRITE(wr), .CMD_READ(rd), .CMD_ADDR(a), .CMD_WDATA(wd),
    .CMD_RDATA(rq), .CMD_RVALID(rv), .BATTERY_PRESENCE_PIN(bp), .BATTERY_ONLY(bo),
    .OTG_MODE(otg), .ADAPTER_PRESENT(ap), .PROCHOT_CFG(cf[5]), .DISCHG_MON_CFG(cf[4]),
    .POWER_MON_CFG(cf[3]), .COMPARATOR_CFG(cf[2]), .OPT1_CMP_BIT14(cf[1]),
    .OPT1_CMP_BIT13(cf[0]), .CHARGE_VALUES_VALID(vv), .PROCHOT_ENABLE(o[10]),
    .DISCHG_MON_ENABLE(o[9]), .POWER_MON_ENABLE(o[8]), .COMPARATOR_ENABLE(o[7]),
    .ADC_AVAILABLE(o[6]), .CHARGE_SUSPEND(o[5]), .ADAPTER_GOOD_OUTPUT(o[4]),
    .INPUT_REG_ENABLE(o[3]), .BURST_LIMIT_ENABLE(o[2]), .SW_FREQ_800K(o[1]),
    .LEARN_ENABLE(o[0]));
  task chk(input [15:0] g, input [15:0] e);
    comparisons = comparisons + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  task close_out;
    $display("errors %0d compares %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task w(input [7:0] ad, input [15:0] d);
    u_host.xfer(1'b1, ad, d);
  endtask
  task r(input [7:0] ad, input [15:0] e);
    eq.push_back(e);
    u_host.xfer(1'b0, ad, 16'h0);
    repeat (2) @(posedge clk);
  endtask
  // waits for the suspend flag to reach a level, bounded
  task ws(input v);
    for (n = 0; n < 40 && o[5] !== v; n = n + 1) @(posedge clk);
    if (n == 40) chk(16'hDEAD, 16'h0);
  endtask
  always @(posedge clk) if (rv === 1'b1) chk(rq, eq.size() ? eq.pop_front() : 16'hDEAD);
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    r(8'h12, 16'hE20E);
    r(8'h20, 16'h0);
    repeat (6) begin
      sd = sd ^ (sd << 13);
      sd = sd ^ (sd >> 17);
      sd = sd ^ (sd << 5);
      cf <= sd[21:16];
      bo <= sd[22];
      w(8'h12, sd[15:0] | 16'h6000);
      r(8'h12, (sd[15:0] | 16'h6000) & 16'hFE3F);
    end
    bo <= 1'b1;
    cf <= 6'h3F;
    w(8'h12, 16'hF022);
    bp <= 1'b0;
    repeat (4) @(posedge clk);
    r(8'h12, 16'hF000);
    chk(o & 16'h07C9, 16'h0080);
    w(8'h12, 16'h6802);
    otg <= 1'b1;
    r(8'h12, 16'h6802);
    chk(o & 16'h07D9, 16'h07D8);
    bp <= 1'b1;
    w(8'h12, 16'h6022);
    bp <= 1'b0;
    repeat (4) @(posedge clk);
    r(8'h12, 16'h6002);
    chk(o & 16'h0010, 16'h0);
    vv <= 1'b0;
    w(8'h12, 16'h2000);
    repeat (8) @(posedge clk);
    chk(o & 16'h0020, 16'h0);
    ws(1'b1);
    w(8'h14, 16'h0);
    repeat (3) @(posedge clk);
    chk(o & 16'h0020, 16'h0020);
    vv <= 1'b1;
    w(8'h15, 16'h0);
    ws(1'b0);
    w(8'h12, 16'h0);
    repeat (40) @(posedge clk);
    chk(o & 16'h0020, 16'h0);
    close_out;
  end
endmodule
bind cow_charger_options cow_properties u_chk(.CLOCK(CLOCK), .RESET(RESET),
  .CMD_WRITE(CMD_WRITE), .CMD_READ(CMD_READ), .CMD_ADDR(CMD_ADDR), .CMD_WDATA(CMD_WDATA),
  .CMD_RDATA(CMD_RDATA), .CMD_RVALID(CMD_RVALID), .PROCHOT_CFG(PROCHOT_CFG),
  .OPT1_CMP_BIT14(OPT1_CMP_BIT14), .OPT1_CMP_BIT13(OPT1_CMP_BIT13),
  .CHARGE_VALUES_VALID(CHARGE_VALUES_VALID), .PROCHOT_ENABLE(PROCHOT_ENABLE),
  .COMPARATOR_ENABLE(COMPARATOR_ENABLE), .ADC_AVAILABLE(ADC_AVAILABLE),
  .CHARGE_SUSPEND(CHARGE_SUSPEND), .BURST_LIMIT_ENABLE(BURST_LIMIT_ENABLE),
  .SW_FREQ_800K(SW_FREQ_800K));
